// ===== shared/dpb_cfg.svh
// Constants for the parameter block decoder and its host end.
// Assumes byte-wide memory reads with a valid/ready handshake.
`ifndef DPB_CFG_SVH
`define DPB_CFG_SVH
`define DPB_BLOCK_LEN 3'h7
`define DPB_MAX_TRACK 8'h4c
`define DPB_MAX_SECTOR 8'h34
`define DPB_SECTOR_BYTES 16'h0080
`define DPB_CW_RANDOM 6
`define DPB_CW_INT_HI 5
`define DPB_CW_INT_LO 4
`define DPB_CW_WORDLEN 3
`define DPB_OP_WORDLEN 3
`define DPB_OP_CODE_HI 2
`define DPB_OP_UNIT_HI 5
`define DPB_OP_UNIT_LO 4
`define DPB_SEC_HI 5
`define DPB_ERR_NOTRDY 7
`define DPB_ERR_WRFAULT 6
`define DPB_ERR_WRPROT 5
`define DPB_ERR_OVERRUN 4
`define DPB_ERR_ADDR 3
`define DPB_ERR_SEEK 2
`define DPB_ERR_CRC 1
`define DPB_ERR_DELETED 0
`define DPB_INT_ALL 2'h0
`define DPB_INT_NONE 2'h1
`define DPB_INT_ILLEGAL 2'h3
`define DPB_APB_CMD 12'h000
`define DPB_APB_STATUS 12'h004
`define DPB_APB_RESULT 12'h008
`define DPB_APB_FIELDS 12'h00c
`endif

// ===== shared/dpb_pkg.sv
// Types used by the decoder end of the parameter block link and by its bench.
// Assumes dpb_cfg.svh supplies all numeric constants.
package dpb_pkg;
    typedef enum logic [2:0] {
        DPB_OP_NOP = 3'h0,
        DPB_OP_SEEK = 3'h1,
        DPB_OP_FORMAT = 3'h2,
        DPB_OP_RECAL = 3'h3,
        DPB_OP_READ = 3'h4,
        DPB_OP_VERIFY = 3'h5,
        DPB_OP_WRITE = 3'h6,
        DPB_OP_WRDEL = 3'h7
    } dpb_op_t;
    typedef enum logic [2:0] {
        DPB_IDLE = 3'h0,
        DPB_FETCH = 3'h1,
        DPB_WAIT = 3'h3,
        DPB_CHECK = 3'h2,
        DPB_BUSY = 3'h6
    } dpb_state_t;
endpackage

// ===== shared/dpb_if.sv
// Link between the host memory side and the parameter block decoder.
// Assumes one clock; memory answers one byte per handshake.
`timescale 1ns/100ps
interface dpb_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic start;
    logic [15:0] start_ptr;
    logic mem_req;
    logic [15:0] mem_addr;
    logic mem_ack;
    logic [7:0] mem_data;
    logic result_rd;
    logic [7:0] result_byte;
    modport device (
        input clk, rst_n, start, start_ptr, mem_ack, mem_data, result_rd,
        output mem_req, mem_addr, result_byte
    );
    modport host (
        input clk, rst_n, mem_req, mem_addr, result_byte,
        output start, start_ptr, mem_ack, mem_data, result_rd
    );
endinterface

// ===== rtl/dpb_decoder.sv
// Parameter block fetcher and decoder, with error byte assembly.
// Assumes the host end answers each memory request with one byte.
//
// Functional notes
// - Start pointer begins block fetch
// - Seven bytes in fixed order
// - Control bit 6 picks format numbering
// - Control bits 5:4 gate completion interrupt
// - Host sets word length bit
// - Opcode word length matches control
// - Opcode bits 5:4 select drive
// - Opcode bits 2:0 select operation
// - Host keeps count within 52
// - Track valid 0 to 4C
// - Sector bits 5:0, 1 to 34
// - Buffer pointer from bytes 6, 7
// - Error byte returned on result read
// - Bit 7 drive not ready
// - Bit 6 drive write fault
// - Bit 5 write protect on writes
// - Bit 4 lost byte transfer
// - Bit 3 address error
// - Bit 2 seek error
// - Bit 1 data check mismatch
// - Bit 0 deleted mark seen
// - Compound error bit patterns
// - Buffer spans count times 128
`timescale 1ns/100ps
`include "dpb_cfg.svh"
module dpb_decoder (
    dpb_if.device LINK,
    input wire logic DRV_NOT_READY,
    input wire logic DRV_WRITE_FAULT,
    input wire logic DRV_WRITE_PROTECT,
    input wire logic DRV_XFER_REQ,
    input wire logic DRV_XFER_DONE,
    input wire logic DRV_SEEK_MISS,
    input wire logic DRV_CRC_MISS,
    input wire logic DRV_DELETED_MARK,
    input wire logic DRV_ID_CRC_MISS,
    input wire logic DRV_NO_ADDR_MARK,
    input wire logic DRV_NO_DATA_MARK,
    input wire logic OP_DONE,
    output logic BUSY,
    output logic DECODED,
    output dpb_pkg::dpb_op_t OPERATION,
    output logic [1:0] DRIVE,
    output logic RANDOM_FORMAT,
    output logic INT_ENABLE,
    output logic INT_ILLEGAL,
    output logic WORD16,
    output logic [7:0] RECORD_COUNT,
    output logic [7:0] TRACK,
    output logic [5:0] SECTOR,
    output logic [15:0] BUFFER_ADDR,
    output logic [15:0] BUFFER_BYTES
);
    dpb_pkg::dpb_state_t state_reg, state_next;
    logic [2:0] idx_reg, idx_next;
    logic [15:0] ptr_reg, ptr_next;
    logic [7:0] blk_reg [0:6];
    logic [7:0] blk_next [0:6];
    logic [7:0] err_reg, err_next;
    logic pend_reg, pend_next;
    logic dec_reg, dec_next;
    logic addr_bad;
    logic is_write;
    logic is_rdver;
    logic [7:0] sec_num;

    assign sec_num = {2'h0, blk_reg[4][`DPB_SEC_HI:0]};
    assign addr_bad = (blk_reg[3] > `DPB_MAX_TRACK) || (sec_num == 8'h00)
        || (sec_num > `DPB_MAX_SECTOR)
        || ((9'(sec_num) + 9'(blk_reg[2])) > 9'(`DPB_MAX_SECTOR));
    assign is_write = (OPERATION == dpb_pkg::DPB_OP_FORMAT)
        || (OPERATION == dpb_pkg::DPB_OP_WRITE) || (OPERATION == dpb_pkg::DPB_OP_WRDEL);
    assign is_rdver = (OPERATION == dpb_pkg::DPB_OP_READ)
        || (OPERATION == dpb_pkg::DPB_OP_VERIFY);

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        ptr_next = ptr_reg;
        err_next = err_reg;
        pend_next = pend_reg;
        dec_next = dec_reg;
        for (int i = 0; i < 7; i++) begin
            blk_next[i] = blk_reg[i];
        end
        case (state_reg)
            dpb_pkg::DPB_IDLE: begin
                if (LINK.start) begin
                    ptr_next = LINK.start_ptr;
                    idx_next = 3'h0;
                    err_next = 8'h00;
                    dec_next = 1'b0;
                    state_next = dpb_pkg::DPB_FETCH;
                end
            end
            dpb_pkg::DPB_FETCH: begin
                if (LINK.mem_ack) begin
                    blk_next[idx_reg] = LINK.mem_data;
                    ptr_next = ptr_reg + 16'h0001;
                    idx_next = idx_reg + 3'h1;
                    if (idx_reg == `DPB_BLOCK_LEN - 3'h1) begin
                        state_next = dpb_pkg::DPB_WAIT;
                    end
                end
            end
            dpb_pkg::DPB_WAIT: begin
                state_next = dpb_pkg::DPB_CHECK;
            end
            dpb_pkg::DPB_CHECK: begin
                dec_next = 1'b1;
                err_next[`DPB_ERR_ADDR] = addr_bad;
                state_next = addr_bad ? dpb_pkg::DPB_IDLE : dpb_pkg::DPB_BUSY;
            end
            dpb_pkg::DPB_BUSY: begin
                if (DRV_NOT_READY) begin
                    err_next[`DPB_ERR_NOTRDY] = 1'b1;
                end
                if (DRV_WRITE_FAULT && is_write) begin
                    err_next[`DPB_ERR_WRFAULT] = 1'b1;
                end
                if (DRV_WRITE_PROTECT && is_write) begin
                    err_next[`DPB_ERR_WRPROT] = 1'b1;
                end
                if (DRV_XFER_REQ && pend_reg && !DRV_XFER_DONE) begin
                    err_next[`DPB_ERR_OVERRUN] = 1'b1;
                end
                if (DRV_XFER_REQ) begin
                    pend_next = 1'b1;
                end else if (DRV_XFER_DONE) begin
                    pend_next = 1'b0;
                end
                if (DRV_SEEK_MISS) begin
                    err_next[`DPB_ERR_SEEK] = 1'b1;
                end
                if (DRV_CRC_MISS && is_rdver) begin
                    err_next[`DPB_ERR_CRC] = 1'b1;
                end
                if (DRV_DELETED_MARK && is_rdver) begin
                    err_next[`DPB_ERR_DELETED] = 1'b1;
                end
                if (DRV_ID_CRC_MISS) begin
                    err_next[`DPB_ERR_ADDR] = 1'b1;
                    err_next[`DPB_ERR_CRC] = 1'b1;
                end
                if (DRV_NO_ADDR_MARK) begin
                    err_next[`DPB_ERR_ADDR] = 1'b1;
                    err_next[`DPB_ERR_SEEK] = 1'b1;
                    err_next[`DPB_ERR_CRC] = 1'b1;
                end
                if (DRV_NO_DATA_MARK) begin
                    err_next[`DPB_ERR_ADDR] = 1'b1;
                    err_next[`DPB_ERR_SEEK] = 1'b1;
                    err_next[`DPB_ERR_CRC] = 1'b1;
                    err_next[`DPB_ERR_DELETED] = 1'b1;
                end
                if (OP_DONE) begin
                    pend_next = 1'b0;
                    state_next = dpb_pkg::DPB_IDLE;
                end
            end
            default: begin
                state_next = dpb_pkg::DPB_IDLE;
            end
        endcase
    end

    always_ff @(posedge LINK.clk or negedge LINK.rst_n) begin
        if (!LINK.rst_n) begin
            state_reg <= dpb_pkg::DPB_IDLE;
            idx_reg <= 3'h0;
            ptr_reg <= 16'h0000;
            err_reg <= 8'h00;
            pend_reg <= 1'b0;
            dec_reg <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                blk_reg[i] <= 8'h00;
            end
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            ptr_reg <= ptr_next;
            err_reg <= err_next;
            pend_reg <= pend_next;
            dec_reg <= dec_next;
            for (int i = 0; i < 7; i++) begin
                blk_reg[i] <= blk_next[i];
            end
        end
    end

    assign LINK.mem_req = (state_reg == dpb_pkg::DPB_FETCH);
    assign LINK.mem_addr = ptr_reg;
    assign LINK.result_byte = err_reg;
    assign BUSY = (state_reg != dpb_pkg::DPB_IDLE);
    assign DECODED = dec_reg;
    assign OPERATION = dpb_pkg::dpb_op_t'(blk_reg[1][`DPB_OP_CODE_HI:0]);
    assign DRIVE = blk_reg[1][`DPB_OP_UNIT_HI:`DPB_OP_UNIT_LO];
    assign RANDOM_FORMAT = blk_reg[0][`DPB_CW_RANDOM];
    assign INT_ENABLE = (blk_reg[0][`DPB_CW_INT_HI:`DPB_CW_INT_LO] == `DPB_INT_ALL);
    assign INT_ILLEGAL = (blk_reg[0][`DPB_CW_INT_HI:`DPB_CW_INT_LO] == `DPB_INT_ILLEGAL);
    assign WORD16 = blk_reg[0][`DPB_CW_WORDLEN];
    assign RECORD_COUNT = blk_reg[2];
    assign TRACK = blk_reg[3];
    assign SECTOR = blk_reg[4][`DPB_SEC_HI:0];
    assign BUFFER_ADDR = {blk_reg[6], blk_reg[5]};
    assign BUFFER_BYTES = 16'(blk_reg[2] * `DPB_SECTOR_BYTES);
endmodule

// ===== rtl/dpb_host.sv
// Host end: APB-programmed starter and byte-wide memory for the block.
// Assumes software loads the block bytes through the fields register.
`timescale 1ns/100ps
`include "dpb_cfg.svh"
module dpb_host (
    dpb_if.host LINK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    logic [7:0] mem [0:255];
    logic [15:0] ptr_reg, ptr_next;
    logic start_reg, start_next;
    logic ack_reg, ack_next;
    logic [7:0] dat_reg, dat_next;
    logic rd_reg, rd_next;
    logic wr_en;
    logic access;

    assign access = PSEL && PENABLE;
    assign wr_en = access && PWRITE && (PADDR == `DPB_APB_FIELDS);

    always_comb begin
        ptr_next = ptr_reg;
        start_next = 1'b0;
        rd_next = 1'b0;
        ack_next = 1'b0;
        dat_next = dat_reg;
        if (access && PWRITE && PADDR == `DPB_APB_CMD) begin
            ptr_next = PWDATA[15:0];
            start_next = 1'b1;
        end
        if (access && !PWRITE && PADDR == `DPB_APB_RESULT) begin
            rd_next = 1'b1;
        end
        if (LINK.mem_req && !ack_reg) begin
            ack_next = 1'b1;
            dat_next = mem[LINK.mem_addr[7:0]];
        end
    end

    always_ff @(posedge LINK.clk or negedge LINK.rst_n) begin
        if (!LINK.rst_n) begin
            ptr_reg <= 16'h0000;
            start_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 8'h00;
            rd_reg <= 1'b0;
        end else begin
            ptr_reg <= ptr_next;
            start_reg <= start_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            rd_reg <= rd_next;
        end
    end

    always_ff @(posedge LINK.clk) begin
        if (wr_en) begin
            mem[PWDATA[15:8]] <= PWDATA[7:0];
        end
    end

    assign LINK.start = start_reg;
    assign LINK.start_ptr = ptr_reg;
    assign LINK.mem_ack = ack_reg;
    assign LINK.mem_data = dat_reg;
    assign LINK.result_rd = rd_reg;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;

    always_comb begin
        case (PADDR)
            `DPB_APB_CMD: PRDATA = {16'h0000, ptr_reg};
            `DPB_APB_STATUS: PRDATA = {31'h0, LINK.mem_req};
            `DPB_APB_RESULT: PRDATA = {24'h0, LINK.result_byte};
            default: PRDATA = 32'h0;
        endcase
    end
endmodule

// ===== verif/dpb_monitor.sv
// Checker for the link between host end and decoder.
// Assumes the bench instantiates it beside the shared link.
`timescale 1ns/100ps
module dpb_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [15:0] start_ptr,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    input wire logic result_rd,
    input wire logic [7:0] result_byte
);
    logic [3:0] got_reg;
    logic [3:0] got_next;
    always_comb begin
        got_next = got_reg;
        if (start && !mem_req)
            got_next = 4'h0;
        else if (mem_req && mem_ack)
            got_next = got_reg + 4'h1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            got_reg <= 4'h0;
        else
            got_reg <= got_next;
    end
    default clocking mc @(posedge clk); endclocking
    default disable iff (!rst_n);
    start_fetch_a: assert property (start && !mem_req |=> mem_req && mem_addr == start_ptr)
        else $error("fetch did not begin at the pointer");
    addr_step_a: assert property ($changed(mem_addr) && !$past(start) |->
        mem_addr == $past(mem_addr) + 16'h1)
        else $error("fetch address did not step by one");
    byte_count_a: assert property (mem_req && mem_ack |-> got_reg < 4'h7)
        else $error("more than seven bytes fetched");
    addr_span_a: assert property (mem_req |-> (mem_addr - start_ptr) < 16'h7)
        else $error("request outside the block");
    block_done_a: assert property (start && !mem_req |-> ##[8:40] got_reg == 4'h7)
        else $error("block fetch incomplete");
    ack_after_a: assert property ($rose(mem_req) |=> mem_ack)
        else $error("host did not answer the request");
    ack_cause_a: assert property (mem_ack |-> $past(mem_req))
        else $error("answer without request");
    result_clear_a: assert property (start && !mem_req |-> ##[1:2] result_byte == 8'h00)
        else $error("error byte not cleared by start");
    result_quiet_a: assert property (mem_req && $past(mem_req) |-> $stable(result_byte))
        else $error("error byte moved during fetch");
    cover property (start && !mem_req);
    cover property (mem_req && mem_ack && got_reg == 4'h6);
    cover property (result_rd && result_byte != 8'h00);
endmodule

// ===== verif/tb_top.sv
// Bench driving the host end over APB and the decoder's drive side.
// Assumes both ends meet in one link; checks via expectation queues.
`timescale 1ns/100ps
`include "dpb_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic [10:0] drv = 11'h0;
    logic op_done = 1'b0;
    logic busy, decoded, rnd, ie, ii, w16, dec_d = 1'b0;
    dpb_pkg::dpb_op_t op;
    logic [1:0] unit;
    logic [7:0] cnt, trk;
    logic [5:0] sec;
    logic [15:0] bufa, bytes;
    logic [63:0] dec_q[$];
    logic [63:0] dec_e;
    logic pslverr;
    logic [63:0] rd_q[$];
    logic [63:0] rd_e;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    wire logic [63:0] dec_act = {busy, op, unit, rnd, ie, ii, w16, cnt, trk, sec, bufa, bytes};
    dpb_if link (.clk(clk), .rst_n(rst_n));
    dpb_host dpb_host_inst (.LINK(link), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    dpb_decoder dpb_decoder_inst (.LINK(link), .DRV_NOT_READY(drv[0]),
        .DRV_WRITE_FAULT(drv[1]), .DRV_WRITE_PROTECT(drv[2]), .DRV_XFER_REQ(drv[3]),
        .DRV_XFER_DONE(drv[4]), .DRV_SEEK_MISS(drv[5]), .DRV_CRC_MISS(drv[6]),
        .DRV_DELETED_MARK(drv[7]), .DRV_ID_CRC_MISS(drv[8]), .DRV_NO_ADDR_MARK(drv[9]),
        .DRV_NO_DATA_MARK(drv[10]), .OP_DONE(op_done), .BUSY(busy), .DECODED(decoded),
        .OPERATION(op), .DRIVE(unit), .RANDOM_FORMAT(rnd), .INT_ENABLE(ie),
        .INT_ILLEGAL(ii), .WORD16(w16), .RECORD_COUNT(cnt), .TRACK(trk), .SECTOR(sec),
        .BUFFER_ADDR(bufa), .BUFFER_BYTES(bytes));
    dpb_monitor dpb_monitor_inst (.clk(link.clk), .rst_n(link.rst_n), .start(link.start),
        .start_ptr(link.start_ptr), .mem_req(link.mem_req), .mem_addr(link.mem_addr),
        .mem_ack(link.mem_ack), .mem_data(link.mem_data), .result_rd(link.result_rd),
        .result_byte(link.result_byte));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cycle ceiling: forty operations need well under this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            give_verdict();
        end
    end
    always @(posedge clk) begin
        dec_d <= decoded;
        if (decoded === 1'b1 && dec_d === 1'b0 && dec_q.size() > 0) begin
            dec_e = dec_q.pop_front();
            `CHK(dec_act, dec_e)
        end
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
            rd_e = rd_q.pop_front();
            `CHK(prdata & rd_e[63:32], rd_e[31:0])
            `CHK(pslverr, 1'b0)
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input int i, input int n);
        drv[i] <= 1'b1;
        repeat (n) @(posedge clk);
        drv[i] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic run_op();
        logic [7:0] b[7];
        logic [7:0] ev[11];
        int pin[11];
        logic [15:0] p;
        logic [7:0] res;
        logic bad, wr, rd;
        int k;
        ev = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01, 8'h0a, 8'h0e, 8'h0f};
        pin = '{0, 0, 1, 2, 3, 5, 6, 7, 8, 9, 10};
        p = {8'($urandom), 8'($urandom_range(0, 248))};
        for (int i = 0; i < 7; i++)
            b[i] = 8'($urandom);
        // Host keeps both word length bits equal
        b[1][3] = b[0][3];
        k = $urandom_range(0, 3);
        b[2] = 8'($urandom_range(0, 12));
        b[3] = k == 0 ? 8'h4d : k == 1 ? 8'h4c : 8'($urandom_range(0, 76));
        b[4][5:0] = k == 2 ? 6'h34 : k == 3 ? 6'($urandom_range(0, 63)) : 6'h01;
        bad = b[3] > 8'h4c || b[4][5:0] == 6'h0 || int'(b[4][5:0]) + int'(b[2]) > 52;
        wr = b[1][2:0] == 3'h2 || b[1][2:0] >= 3'h6;
        rd = b[1][2:0] == 3'h4 || b[1][2:0] == 3'h5;
        for (int i = 0; i < 7; i++)
            apb(1'b1, `DPB_APB_FIELDS, {16'h0, p[7:0] + 8'(i), b[i]});
        dec_q.push_back({!bad, b[1][2:0], b[1][5:4], b[0][6], b[0][5:4] == 2'h0,
            b[0][5:4] == 2'h3, b[0][3], b[2], b[3], b[4][5:0], b[6], b[5], 1'b0, b[2], 7'h0});
        apb(1'b1, `DPB_APB_CMD, {16'h0, p});
        while (decoded !== 1'b0) @(posedge clk);
        while (decoded !== 1'b1) @(posedge clk);
        res = 8'h08;
        if (!bad) begin
            k = $urandom_range(0, 10);
            if ((k == 6 || k == 7) && !rd)
                k = 0;
            res = ((k == 2 || k == 3) && !wr) ? 8'h00 : ev[k];
            pulse(3, 1);
            if (k == 4)
                pulse(3, 1);
            pulse(4, 1);
            if (k != 0 && k != 4)
                pulse(pin[k], 2);
            op_done <= 1'b1;
            @(posedge clk);
            op_done <= 1'b0;
            while (busy !== 1'b0) @(posedge clk);
        end
        rd_q.push_back({32'h1, 32'h0});
        apb(1'b0, `DPB_APB_STATUS, 32'h0);
        rd_q.push_back({32'hff, 24'h0, res});
        apb(1'b0, `DPB_APB_RESULT, 32'h0);
        rd_q.push_back({32'hffff, 16'h0, p});
        apb(1'b0, `DPB_APB_CMD, 32'h0);
    endtask
    initial begin
        void'($urandom(32'h4beb));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_q.push_back({32'hff, 32'h0});
        apb(1'b0, `DPB_APB_RESULT, 32'h0);
        apb(1'b1, 12'h014, 32'h5a);
        rd_q.push_back({32'hffffffff, 32'h0});
        apb(1'b0, 12'h014, 32'h0);
        repeat (40) run_op();
        give_verdict();
    end
endmodule
